// *** hw/servo_input_pkg.sv ***
// Constants, register map and types for the servo input and gain block.
package servo_input_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   localparam int N_GAINS = 7;
   localparam int SET_W = 4;
   localparam int BLEND_W = 9;
   // Register byte offsets.
   localparam logic [7:0] FAULT_CLEAR_MAP_OFS = 8'h00;
   localparam logic [7:0] REVERSE_STOP_MAP_OFS = 8'h04;
   localparam logic [7:0] FORWARD_STOP_MAP_OFS = 8'h08;
   localparam logic [7:0] INPUT_CFG_OFS = 8'h0C;
   localparam logic [7:0] STATUS_OFS = 8'h10;
   localparam logic [7:0] TRIGGER_SELECT_OFS = 8'h14;
   localparam logic [7:0] POSITION_THRESHOLD_OFS = 8'h18;
   localparam logic [7:0] SPEED_THRESHOLD_OFS = 8'h1C;
   localparam logic [7:0] TORQUE_THRESHOLD_OFS = 8'h60;
   localparam logic [7:0] RETURN_DELAY_OFS = 8'h64;
   localparam logic [7:0] MOVE_DELAY_OFS = 8'h68;
   localparam logic [2:0] GAIN_SET1_PAGE = 3'h1;
   localparam logic [2:0] GAIN_SET2_PAGE = 3'h2;
   // Input configuration fields.
   localparam int CFG_ENABLE_ASSIGNED_BIT = 0;
   localparam int CFG_GAIN_SELECT_ASSIGNED_BIT = 1;
   localparam int CFG_GAIN_SELECT_LSB = 4;
   // Status fields.
   localparam int STAT_ALARM_BIT = 0;
   localparam int STAT_ENABLE_BIT = 1;
   localparam int STAT_REVERSE_BIT = 2;
   localparam int STAT_FORWARD_BIT = 3;
   localparam int STAT_PRIMED_BIT = 4;
   localparam int STAT_STATE_LSB = 8;
   localparam int STAT_BLEND_LSB = 16;
   // Input logic settings.
   localparam logic [3:0] FC_FALLING_CLEARS = 4'h3;
   localparam logic [3:0] FC_RISING_CLEARS = 4'h4;
   localparam logic [3:0] FWD_ACTIVE_CLOSED = 4'h5;
   localparam logic [3:0] FWD_ACTIVE_OPEN = 4'h6;
   localparam logic [3:0] REV_ACTIVE_CLOSED = 4'h7;
   localparam logic [3:0] REV_ACTIVE_OPEN = 4'h8;
   localparam logic [3:0] GSEL_SECOND_CLOSED = 4'hB;
   localparam logic [3:0] GSEL_SECOND_OPEN = 4'hC;
   // Automatic switching triggers.
   localparam logic [3:0] TRIG_FIXED_FIRST = 4'h0;
   localparam logic [3:0] TRIG_POSITION = 4'h1;
   localparam logic [3:0] TRIG_SPEED = 4'h2;
   localparam logic [3:0] TRIG_TORQUE = 4'h3;
   localparam logic [3:0] TRIG_NOT_IN_POSITION = 4'h4;
   // Reset values.
   localparam logic [3:0] FAULT_CLEAR_MAP_RST = FC_FALLING_CLEARS;
   localparam logic [3:0] REVERSE_STOP_MAP_RST = REV_ACTIVE_CLOSED;
   localparam logic [3:0] FORWARD_STOP_MAP_RST = FWD_ACTIVE_CLOSED;
   localparam logic [3:0] TRIGGER_SELECT_RST = TRIG_FIXED_FIRST;
   localparam logic [31:0] POSITION_THRESHOLD_RST = 32'h0000_0000;
   localparam logic [31:0] SPEED_THRESHOLD_RST = 32'h0000_0000;
   localparam logic [31:0] TORQUE_THRESHOLD_RST = 32'h0000_000A;
   localparam logic [15:0] RETURN_DELAY_RST = 16'h000A;
   localparam logic [15:0] MOVE_DELAY_RST = 16'h000A;
   localparam logic ENABLE_ASSIGNED_RST = 1'b1;
   localparam logic GAIN_SELECT_ASSIGNED_RST = 1'b0;
   localparam logic [3:0] GAIN_SELECT_MAP_RST = GSEL_SECOND_CLOSED;
   typedef logic [15:0] gain_t;
   // Order: position gain, differential time, differential filter,
   // command speed gain, speed gain, speed integral time, torque filter.
   localparam gain_t GAIN_RST [N_GAINS] = '{16'h0034, 16'h0000, 16'h4E20,
      16'h2710, 16'h00B7, 16'h00BD, 16'h044B};
   // Timing.
   localparam int MS_IN_NS = 1000000;
   localparam int CLK_PERIOD_NS = 4;
   localparam int CYCLES_PER_MS = MS_IN_NS / CLK_PERIOD_NS;
   localparam logic [BLEND_W-1:0] BLEND_FULL = 9'h100;
   typedef enum logic [3:0] {
      ST_FIRST = 4'b0001,
      ST_TO_SECOND = 4'b0010,
      ST_SECOND = 4'b0100,
      ST_TO_FIRST = 4'b1000
   } gain_state_e;
endpackage

// *** hw/servo_input_gain_select.sv ***
// Contact input conditioning, alarm clear, travel limits and gain blending.
// What this block does
// - Setting 3: open-to-closed edge clears alarm.
// - Steady level or wrong edge never clears.
// - Setting 4: closed-to-open edge clears alarm.
// - No enable pin: fault clear enables drive.
// - Reverse stop: 7 closed, 8 open; inhibit.
// - Forward stop: 5 closed, 6 open; inhibit.
// - Reverse on input one, forward input two.
// - Two independent seven-entry gain sets.
// - Gain defaults 52, 183, 189 ms.
// - Defaults 10000, 20000, 1099.
// - Trigger select resets to fixed first set.
// - Thresholds: counts, 0.025rps, 0.1% default 10.
// - Return delay in ms, default 10.
// - Move delay in ms, default 10.
// - Trigger: position, speed, torque, not in position.
// - Assigned select input overrides automatic switching.
// - Gains blend gradually over the delay.
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module servo_input_gain_select #(
   parameter int CYCLES_PER_MS = servo_input_pkg::CYCLES_PER_MS
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [servo_input_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [servo_input_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [servo_input_pkg::DATA_W-1:0] reg_rdata,
   input wire logic contact_input_one,
   input wire logic contact_input_two,
   input wire logic fault_clear_in,
   input wire logic servo_enable_in,
   input wire logic gain_select_in,
   input wire logic alarm_event,
   input wire logic signed [31:0] position_error,
   input wire logic signed [15:0] actual_speed,
   input wire logic signed [15:0] actual_torque,
   input wire logic in_position,
   output logic alarm_active,
   output logic drive_enable,
   output logic reverse_stop_in,
   output logic forward_stop_in,
   output logic [servo_input_pkg::BLEND_W-1:0] gain_blend,
   output servo_input_pkg::gain_t gain_out [servo_input_pkg::N_GAINS]
);
   import servo_input_pkg::*;

   function automatic logic [31:0] magnitude(input logic signed [31:0] v);
      magnitude = v[31] ? 32'(-v) : 32'(v);
   endfunction

   function automatic gain_t blend_gain(input gain_t a, input gain_t b,
                                        input logic [BLEND_W-1:0] f);
      logic signed [26:0] prod;
      prod = 27'(($signed({1'b0, b}) - $signed({1'b0, a}))
             * $signed({1'b0, f}));
      blend_gain = 16'($signed({1'b0, a}) + (prod >>> 8));
   endfunction

   // Bit order: gain select, enable, fault clear, input two, input one.
   localparam int N_IN = 5;
   logic [N_IN-1:0] pins;
   logic [N_IN-1:0] sync1_q, sync2_q, prev_q;
   logic [1:0] prime_q;
   logic primed;
   assign pins = {gain_select_in, servo_enable_in, fault_clear_in,
                  contact_input_two, contact_input_one};

   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_q <= '1;
         sync2_q <= '1;
         prev_q <= '1;
      end else begin
         sync1_q <= pins;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end

   // Edges are only believed once the pipeline holds real samples.
   always_ff @(posedge clk) begin
      if (rst)
         prime_q <= 2'h0;
      else if (prime_q != 2'h3)
         prime_q <= prime_q + 2'h1;
   end
   assign primed = (prime_q == 2'h3);

   logic [3:0] fault_clear_map_q, reverse_stop_map_q, forward_stop_map_q;
   logic [3:0] trigger_select_q, gain_select_map_q;
   logic enable_assigned_q, gain_select_assigned_q;
   logic [31:0] position_threshold_q, speed_threshold_q, torque_threshold_q;
   logic [15:0] return_delay_q, move_delay_q;
   gain_t gain_q [2][N_GAINS];
   logic gain_wr;
   assign gain_wr = reg_write && reg_addr[4:2] != 3'h7
      && (reg_addr[7:5] == GAIN_SET1_PAGE || reg_addr[7:5] == GAIN_SET2_PAGE);

   always_ff @(posedge clk) begin
      if (rst) begin
         fault_clear_map_q <= FAULT_CLEAR_MAP_RST;
         reverse_stop_map_q <= REVERSE_STOP_MAP_RST;
         forward_stop_map_q <= FORWARD_STOP_MAP_RST;
         trigger_select_q <= TRIGGER_SELECT_RST;
         gain_select_map_q <= GAIN_SELECT_MAP_RST;
         enable_assigned_q <= ENABLE_ASSIGNED_RST;
         gain_select_assigned_q <= GAIN_SELECT_ASSIGNED_RST;
         position_threshold_q <= POSITION_THRESHOLD_RST;
         speed_threshold_q <= SPEED_THRESHOLD_RST;
         torque_threshold_q <= TORQUE_THRESHOLD_RST;
         return_delay_q <= RETURN_DELAY_RST;
         move_delay_q <= MOVE_DELAY_RST;
      end else if (reg_write) begin
         unique case (reg_addr)
            FAULT_CLEAR_MAP_OFS: fault_clear_map_q <= reg_wdata[3:0];
            REVERSE_STOP_MAP_OFS: reverse_stop_map_q <= reg_wdata[3:0];
            FORWARD_STOP_MAP_OFS: forward_stop_map_q <= reg_wdata[3:0];
            INPUT_CFG_OFS: begin
               enable_assigned_q <= reg_wdata[CFG_ENABLE_ASSIGNED_BIT];
               gain_select_assigned_q <=
                  reg_wdata[CFG_GAIN_SELECT_ASSIGNED_BIT];
               gain_select_map_q <=
                  reg_wdata[CFG_GAIN_SELECT_LSB +: SET_W];
            end
            TRIGGER_SELECT_OFS: trigger_select_q <= reg_wdata[3:0];
            POSITION_THRESHOLD_OFS: position_threshold_q <= reg_wdata;
            SPEED_THRESHOLD_OFS: speed_threshold_q <= reg_wdata;
            TORQUE_THRESHOLD_OFS: torque_threshold_q <= reg_wdata;
            RETURN_DELAY_OFS: return_delay_q <= reg_wdata[15:0];
            MOVE_DELAY_OFS: move_delay_q <= reg_wdata[15:0];
            default: ;
         endcase
      end
   end

   // Each set is written on its own page; both reset to one default table.
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int s = 0; s < 2; s++)
            for (int k = 0; k < N_GAINS; k++)
               gain_q[s][k] <= GAIN_RST[k];
      end else if (gain_wr) begin
         gain_q[reg_addr[6]][reg_addr[4:2]] <= reg_wdata[15:0];
      end
   end

   // Low pin level means closed, high means open.
   logic fc_now, fc_prev, clear_edge;
   assign fc_now = sync2_q[2];
   assign fc_prev = prev_q[2];
   always_comb begin
      clear_edge = 1'b0;
      if (primed) begin
         if (fault_clear_map_q == FC_FALLING_CLEARS)
            clear_edge = fc_prev && !fc_now;
         else if (fault_clear_map_q == FC_RISING_CLEARS)
            clear_edge = !fc_prev && fc_now;
      end
   end

   // A new fault in the clearing cycle keeps the alarm standing.
   always_ff @(posedge clk) begin
      if (rst)
         alarm_active <= 1'b0;
      else if (alarm_event)
         alarm_active <= 1'b1;
      else if (clear_edge)
         alarm_active <= 1'b0;
   end

   // Without an enable pin the fault clear input held at its post-edge
   // level enables the drive.
   logic fc_enable_level;
   assign fc_enable_level = (fault_clear_map_q == FC_RISING_CLEARS)
      ? fc_now : !fc_now;
   always_ff @(posedge clk) begin
      if (rst)
         drive_enable <= 1'b0;
      else if (enable_assigned_q)
         drive_enable <= !sync2_q[3] && !alarm_active;
      else
         drive_enable <= fc_enable_level && !alarm_active;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         reverse_stop_in <= 1'b0;
         forward_stop_in <= 1'b0;
      end else begin
         reverse_stop_in <=
            (reverse_stop_map_q == REV_ACTIVE_CLOSED && !sync2_q[0]) ||
            (reverse_stop_map_q == REV_ACTIVE_OPEN && sync2_q[0]);
         forward_stop_in <=
            (forward_stop_map_q == FWD_ACTIVE_CLOSED && !sync2_q[1]) ||
            (forward_stop_map_q == FWD_ACTIVE_OPEN && sync2_q[1]);
      end
   end

   logic want_second;
   always_comb begin
      want_second = 1'b0;
      if (gain_select_assigned_q) begin
         want_second = (gain_select_map_q == GSEL_SECOND_OPEN)
            ? sync2_q[4] : !sync2_q[4];
      end else begin
         unique case (trigger_select_q)
            TRIG_POSITION: want_second =
               magnitude(position_error) >= position_threshold_q;
            TRIG_SPEED: want_second =
               magnitude(32'(actual_speed)) >= speed_threshold_q;
            TRIG_TORQUE: want_second =
               magnitude(32'(actual_torque)) >= torque_threshold_q;
            TRIG_NOT_IN_POSITION: want_second = !in_position;
            default: want_second = 1'b0;
         endcase
      end
   end

   // The blend steps by one 1/256 each time the accumulator passes span,
   // so 256 steps take the programmed delay.
   gain_state_e state_q;
   logic [47:0] acc_q, acc_step, span_up, span_dn;
   assign span_up = 48'(move_delay_q) * 48'(CYCLES_PER_MS);
   assign span_dn = 48'(return_delay_q) * 48'(CYCLES_PER_MS);
   assign acc_step = acc_q + 48'h100;

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= ST_FIRST;
         gain_blend <= '0;
         acc_q <= '0;
      end else begin
         unique case (state_q)
            ST_FIRST: if (want_second) begin
               state_q <= ST_TO_SECOND;
               acc_q <= '0;
            end
            ST_SECOND: if (!want_second) begin
               state_q <= ST_TO_FIRST;
               acc_q <= '0;
            end
            ST_TO_SECOND: begin
               if (!want_second) begin
                  state_q <= ST_TO_FIRST;
                  acc_q <= '0;
               end else if (span_up == '0 || gain_blend == BLEND_FULL) begin
                  gain_blend <= BLEND_FULL;
                  state_q <= ST_SECOND;
               end else if (acc_step >= span_up) begin
                  gain_blend <= gain_blend + 9'h001;
                  acc_q <= acc_step - span_up;
               end else begin
                  acc_q <= acc_step;
               end
            end
            ST_TO_FIRST: begin
               if (want_second) begin
                  state_q <= ST_TO_SECOND;
                  acc_q <= '0;
               end else if (span_dn == '0 || gain_blend == '0) begin
                  gain_blend <= '0;
                  state_q <= ST_FIRST;
               end else if (acc_step >= span_dn) begin
                  gain_blend <= gain_blend - 9'h001;
                  acc_q <= acc_step - span_dn;
               end else begin
                  acc_q <= acc_step;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         for (int k = 0; k < N_GAINS; k++)
            gain_out[k] <= GAIN_RST[k];
      end else begin
         for (int k = 0; k < N_GAINS; k++)
            gain_out[k] <= blend_gain(gain_q[0][k], gain_q[1][k],
                                      gain_blend);
      end
   end

   logic [DATA_W-1:0] rd_mux;
   always_comb begin
      rd_mux = '0;
      if (reg_addr[7:5] == GAIN_SET1_PAGE || reg_addr[7:5] == GAIN_SET2_PAGE)
      begin
         if (reg_addr[4:2] != 3'h7)
            rd_mux = 32'(gain_q[reg_addr[6]][reg_addr[4:2]]);
      end else begin
         unique case (reg_addr)
            FAULT_CLEAR_MAP_OFS: rd_mux = 32'(fault_clear_map_q);
            REVERSE_STOP_MAP_OFS: rd_mux = 32'(reverse_stop_map_q);
            FORWARD_STOP_MAP_OFS: rd_mux = 32'(forward_stop_map_q);
            INPUT_CFG_OFS: begin
               rd_mux[CFG_ENABLE_ASSIGNED_BIT] = enable_assigned_q;
               rd_mux[CFG_GAIN_SELECT_ASSIGNED_BIT] = gain_select_assigned_q;
               rd_mux[CFG_GAIN_SELECT_LSB +: SET_W] = gain_select_map_q;
            end
            STATUS_OFS: begin
               rd_mux[STAT_ALARM_BIT] = alarm_active;
               rd_mux[STAT_ENABLE_BIT] = drive_enable;
               rd_mux[STAT_REVERSE_BIT] = reverse_stop_in;
               rd_mux[STAT_FORWARD_BIT] = forward_stop_in;
               rd_mux[STAT_PRIMED_BIT] = primed;
               rd_mux[STAT_STATE_LSB +: 4] = state_q;
               rd_mux[STAT_BLEND_LSB +: BLEND_W] = gain_blend;
            end
            TRIGGER_SELECT_OFS: rd_mux = 32'(trigger_select_q);
            POSITION_THRESHOLD_OFS: rd_mux = position_threshold_q;
            SPEED_THRESHOLD_OFS: rd_mux = speed_threshold_q;
            TORQUE_THRESHOLD_OFS: rd_mux = torque_threshold_q;
            RETURN_DELAY_OFS: rd_mux = 32'(return_delay_q);
            MOVE_DELAY_OFS: rd_mux = 32'(move_delay_q);
            default: rd_mux = '0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst)
         reg_rdata <= '0;
      else
         reg_rdata <= reg_read ? rd_mux : '0;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_clear_falling;
      alarm_active && !alarm_event && primed
         && fault_clear_map_q == FC_FALLING_CLEARS
         && prev_q[2] && !sync2_q[2] |=> !alarm_active;
   endproperty
   a_clear_falling: assert property (p_clear_falling)
      else $error("falling fault clear edge did not clear alarm");

   property p_no_clear_without_edge;
      alarm_active && prev_q[2] == sync2_q[2] |=> alarm_active;
   endproperty
   a_no_clear_without_edge: assert property (p_no_clear_without_edge)
      else $error("alarm cleared by a steady level");

   property p_clear_rising;
      alarm_active && !alarm_event && primed
         && fault_clear_map_q == FC_RISING_CLEARS
         && !prev_q[2] && sync2_q[2] |=> !alarm_active;
   endproperty
   a_clear_rising: assert property (p_clear_rising)
      else $error("rising fault clear edge did not clear alarm");

   property p_shared_enable;
      !enable_assigned_q && !alarm_active
         && fault_clear_map_q == FC_FALLING_CLEARS
         ##1 !$past(sync2_q[2]) |-> drive_enable;
   endproperty
   a_shared_enable: assert property (p_shared_enable)
      else $error("fault clear input did not enable the drive");

   property p_reverse_stop;
      reverse_stop_map_q == REV_ACTIVE_OPEN && sync2_q[0]
         |=> reverse_stop_in;
   endproperty
   a_reverse_stop: assert property (p_reverse_stop)
      else $error("open reverse stop not reported");

   property p_forward_stop;
      forward_stop_map_q == FWD_ACTIVE_CLOSED && !sync2_q[1]
         |=> forward_stop_in;
   endproperty
   a_forward_stop: assert property (p_forward_stop)
      else $error("closed forward stop not reported");

   property p_fixed_first;
      !gain_select_assigned_q && trigger_select_q == TRIG_FIXED_FIRST
         && state_q == ST_FIRST |=> state_q == ST_FIRST;
   endproperty
   a_fixed_first: assert property (p_fixed_first)
      else $error("left first gain set with fixed selection");

   property p_external_override;
      gain_select_assigned_q && gain_select_map_q == GSEL_SECOND_CLOSED
         && !sync2_q[4] && state_q == ST_FIRST |=> state_q == ST_TO_SECOND;
   endproperty
   a_external_override: assert property (p_external_override)
      else $error("closed select input did not start switching");

   property p_gradual;
      span_up != '0 && span_dn != '0 |=>
         gain_blend - $past(gain_blend) <= 9'h001
         || $past(gain_blend) - gain_blend <= 9'h001;
   endproperty
   a_gradual: assert property (p_gradual)
      else $error("gain blend jumped by more than one step");

   property p_sync_edge;
      1'b1 |=> prev_q == $past(sync2_q);
   endproperty
   a_sync_edge: assert property (p_sync_edge)
      else $error("edge sample is not the previous synced value");

   property p_primed;
      !primed |-> !clear_edge;
   endproperty
   a_primed: assert property (p_primed)
      else $error("alarm clear before inputs were sampled");

   c_clear_falling: cover property (alarm_active ##1 !alarm_active
      && fault_clear_map_q == FC_FALLING_CLEARS);
   c_clear_rising: cover property (alarm_active ##1 !alarm_active
      && fault_clear_map_q == FC_RISING_CLEARS);
   c_second_set: cover property (state_q == ST_SECOND);
   c_reverse_stop: cover property (reverse_stop_in && forward_stop_in);
endmodule // servo_input_gain_select

// *** tb/contact_partner.sv ***
// Model of the limit switches and the host contact outputs.
`timescale 1ns/1ps
module contact_partner (
   input wire logic clk,
   input wire logic fc_closed,
   input wire logic rev_closed,
   input wire logic fwd_closed,
   output logic fault_clear_in = 1'b1,
   output logic contact_input_one = 1'b1,
   output logic contact_input_two = 1'b1
);
   // Contacts read low when closed and change only at clock edges.
   always_ff @(posedge clk) begin
      fault_clear_in <= ~fc_closed;
      contact_input_one <= ~rev_closed;
      contact_input_two <= ~fwd_closed;
   end
endmodule // contact_partner

// *** tb/servo_input_gain_select_bench.sv ***
// Self-checking bench for the servo input and gain select block.
`timescale 1ns/1ps
module servo_input_gain_select_bench;
   import servo_input_pkg::*;
   logic clk = 0, rst = 1, reg_write = 0, reg_read = 0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, rv;
   logic servo_enable_in = 1, gain_select_in = 1, alarm_event = 0;
   logic in_position = 1, fc_closed = 0, rev_closed = 0, fwd_closed = 0;
   logic signed [31:0] position_error = 0;
   logic signed [15:0] actual_speed = 0, actual_torque = 0;
   logic fault_clear_in, contact_input_one, contact_input_two;
   logic alarm_active, drive_enable, reverse_stop_in, forward_stop_in;
   logic [8:0] gain_blend;
   gain_t gain_out [N_GAINS];
   int error_cnt = 0, checks_done = 0, n;
   // Cycles per millisecond; 32, so a delay of at least 8 ms spans at least 256
   // clocks and one blend step per clock is enough to spread 256 steps over it.
   localparam int CPM = 32;
   logic [31:0] seed = 32'h0000_001E;
   always #2 clk = ~clk;
   contact_partner far (.clk, .fc_closed, .rev_closed, .fwd_closed,
      .fault_clear_in, .contact_input_one, .contact_input_two);
   servo_input_gain_select #(.CYCLES_PER_MS(CPM)) dut (.clk, .rst,
      .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
      .contact_input_one, .contact_input_two, .fault_clear_in,
      .servo_enable_in, .gain_select_in, .alarm_event, .position_error,
      .actual_speed, .actual_torque, .in_position, .alarm_active,
      .drive_enable, .reverse_stop_in, .forward_stop_in, .gain_blend,
      .gain_out);
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic step(int c);
      repeat (c) @(posedge clk);
      #1;
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic fc(logic closed);
      @(posedge clk);
      fc_closed <= closed;
      step(6);
   endtask
   task automatic raise();
      @(posedge clk);
      alarm_event <= 1'b1;
      @(posedge clk);
      alarm_event <= 1'b0;
      step(1);
      chk("alarm", alarm_active, 1'b1);
   endtask
   task automatic cause(int t, logic on);
      @(posedge clk);
      position_error <= (t == 1 && on) ? -32'sd200 : 32'(xs() % 100);
      actual_speed <= (t == 2 && on) ? -16'sd200 : 16'sd5;
      actual_torque <= (t == 3 && on) ? 16'sd200 : -16'sd5;
      in_position <= !(t == 4 && on);
   endtask
   task automatic wait_for(logic [8:0] v, output int c);
      c = 0;
      while (gain_blend !== v && c < 400) begin
         step(1);
         c++;
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      #100000;
      error_cnt++;
      end_sim();
   end
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      for (int k = 0; k < N_GAINS; k++) begin
         rd(8'h20 + 8'(4 * k), rv);
         chk("set1", rv, 32'(GAIN_RST[k]));
         rd(8'h40 + 8'(4 * k), rv);
         chk("set2", rv, 32'(GAIN_RST[k]));
         chk("gain_out", gain_out[k], 32'(GAIN_RST[k]));
      end
      rd(TRIGGER_SELECT_OFS, rv);
      chk("trigger", rv, 32'h0);
      rd(TORQUE_THRESHOLD_OFS, rv);
      chk("torque_thr", rv, 32'hA);
      rd(RETURN_DELAY_OFS, rv);
      chk("return_delay", rv, 32'hA);
      rd(MOVE_DELAY_OFS, rv);
      chk("move_delay", rv, 32'hA);
      rd(REVERSE_STOP_MAP_OFS, rv);
      chk("rev_map", rv, 32'h7);
      rd(8'hF0, rv);
      chk("unmapped", rv, 32'h0);
      $display("test reset values done");
      for (int i = 0; i < 16; i++) begin
         rv = xs();
         wr(REVERSE_STOP_MAP_OFS, rv[0] ? 32'h8 : 32'h7);
         wr(FORWARD_STOP_MAP_OFS, rv[1] ? 32'h6 : 32'h5);
         rev_closed <= rv[2];
         fwd_closed <= rv[3];
         step(6);
         chk("rev", reverse_stop_in, rv[2] ^ rv[0]);
         chk("fwd", forward_stop_in, rv[3] ^ rv[1]);
      end
      $display("test limits done");
      wr(INPUT_CFG_OFS, 32'h0000_00B0);
      for (int s = 3; s <= 4; s++) begin
         wr(FAULT_CLEAR_MAP_OFS, 32'(s));
         fc(s == 4);
         raise();
         fc(s == 3);
         chk("clear", alarm_active, 1'b0);
         raise();
         step(20);
         chk("steady", alarm_active, 1'b1);
         fc(s == 4);
         chk("wrong_edge", alarm_active, 1'b1);
         fc(s == 3);
         chk("clear2", alarm_active, 1'b0);
         chk("shared_en", drive_enable, 1'b1);
      end
      wr(INPUT_CFG_OFS, 32'h0000_00B1);
      step(6);
      chk("pin_en", drive_enable, 1'b0);
      $display("test fault clear done");
      wr(RETURN_DELAY_OFS, 32'h8);
      wr(POSITION_THRESHOLD_OFS, 32'd100);
      wr(SPEED_THRESHOLD_OFS, 32'd100);
      wr(TORQUE_THRESHOLD_OFS, 32'd100);
      for (int k = 0; k < N_GAINS; k++) begin
         wr(8'h40 + 8'(4 * k), 32'(k + 1));
      end
      for (int t = 1; t <= 4; t++) begin
         wr(TRIGGER_SELECT_OFS, 32'(t));
         cause(t, 1'b1);
         step(10);
         chk("mid_up", gain_blend inside {[1:255]}, 1'b1);
         wait_for(9'h100, n);
         chk("move_time", (n + 10 >= 10 * CPM) && (n + 10 <= 10 * CPM + 4),
             1'b1);
         step(2);
         for (int k = 0; k < N_GAINS; k++) begin
            chk("second", gain_out[k], 32'(k + 1));
         end
         cause(t, 1'b0);
         step(4);
         chk("mid_down", gain_blend inside {[1:255]}, 1'b1);
         wait_for(9'h000, n);
         chk("return_time", (n + 4 >= 8 * CPM) && (n + 4 <= 8 * CPM + 4),
             1'b1);
         step(2);
         chk("first", gain_out[0], 32'(GAIN_RST[0]));
      end
      wr(TRIGGER_SELECT_OFS, 32'h0);
      cause(1, 1'b1);
      step(60);
      chk("fixed", gain_blend, 9'h000);
      wr(INPUT_CFG_OFS, 32'h0000_00B3);
      gain_select_in <= 1'b0;
      step(340);
      chk("ext_second", gain_blend, 9'h100);
      wr(TRIGGER_SELECT_OFS, 32'h1);
      gain_select_in <= 1'b1;
      step(280);
      chk("ext_first", gain_blend, 9'h000);
      $display("test gain switching done");
      end_sim();
   end
endmodule // servo_input_gain_select_bench
